/* tcs_pkg.sv */
// Purpose: Shared constants and types for the termination calibration sequencer
// Assumes: Single system clock; all calibration controls arrive as pins
// Notes:   Counts are in calibration clock edges unless named otherwise
package tcs_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NUM_BLOCKS  = 8;           // Calibration blocks
   localparam int NUM_BANKS   = 8;           // I/O banks receiving codes
   localparam int CODE_BITS   = 32;          // Full code width
   localparam int SERIES_BITS = 16;          // Series half, low bits
   localparam int PAR_BITS    = 16;          // Parallel half, high bits
   localparam int BIT_CNT_W   = 6;           // Width of the shift bit counter
   localparam int CAL_CNT_W   = 10;          // Width of the calibration counter
   localparam int FIFO_DEPTH  = 8;           // Serial path buffer depth
   localparam int FIFO_WIDTH  = 1;           // One code bit per entry

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int SYS_CLK_HZ       = 25000000;   // clk_sys rate
   localparam int CAL_CLK_MAX_HZ   = 20000000;   // Highest calibration clock
   localparam int CAL_CYCLES       = 1000;       // Calibration length
   localparam int LOAD_MIN_NS      = 25;         // Least load enable width
   localparam int SYS_PERIOD_NS    = 1000000000 / SYS_CLK_HZ;
   localparam int LOAD_MIN_CYCLES  = (LOAD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);
   localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(CODE_BITS - 1);
   localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 6'h00;
   localparam logic [CAL_CNT_W-1:0] CAL_ZERO = 10'h000;
   localparam logic [CODE_BITS-1:0] CODE_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Per-block state, Gray along idle -> calibrating -> done
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      TCS_IDLE = 2'h0,
      TCS_CAL  = 2'h1,
      TCS_DONE = 2'h3
   } tcs_blk_e;

endpackage : tcs_pkg

/* tcs_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes:   Full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ns
module tcs_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             in_valid,   // Producer offers a word
   output logic                  in_ready,   // Room for a word
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,  // A word is waiting
   input  wire logic             out_ready,  // Consumer takes it
   output logic      [WIDTH-1:0] out_data
);

   // ----------------------------------------------------------------------
   // Storage and pointers
   // ----------------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];      // Word storage
   logic [AW-1:0]    wr_ptr_reg;           // Next write slot
   logic [AW-1:0]    rd_ptr_reg;           // Next read slot
   logic [AW:0]      count_reg;            // Words held

   wire do_wr = in_valid && in_ready;      // Accepted write
   wire do_rd = out_valid && out_ready;    // Accepted read

   assign in_ready  = (count_reg != CNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem_reg[rd_ptr_reg];

   // Pointer and count update
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   // Word write
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

endmodule : tcs_fifo

/* tcs_sequencer.sv */
// Purpose: Calibration blocks, code serializer and per-bank parallel load
// Assumes: All control pins change on the calibration clock rising edge
// Notes:   The calibration clock is sampled in clk_sys and turned into an edge enable
`timescale 1ns/1ns

module tcs_sequencer (
   input  wire logic                                            clk_sys,
   input  wire logic                                            resetn,
   input  wire logic                                            cal_clock,
   input  wire logic                                            cal_mode_select,
   input  wire logic [tcs_pkg::NUM_BLOCKS-1:0]                  block_enable,
   input  wire logic                                            cal_clear_n,
   input  wire logic [tcs_pkg::NUM_BANKS-1:0]                   bank_parallel_load,
   input  wire logic [tcs_pkg::NUM_BANKS-1:0]                   bank_listen,
   input  wire logic [tcs_pkg::CODE_BITS-1:0]                   measured_code,
   output logic      [tcs_pkg::NUM_BLOCKS-1:0]                  cal_busy,
   output logic      [tcs_pkg::NUM_BLOCKS-1:0]                  cal_done,
   output logic      [tcs_pkg::NUM_BANKS-1:0]                   bank_loading,
   output logic      [tcs_pkg::NUM_BANKS*tcs_pkg::CODE_BITS-1:0] bank_code,
   output logic                                                 serial_path_ready
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   localparam int SYN_W = 2 + tcs_pkg::NUM_BLOCKS + tcs_pkg::NUM_BANKS;

   logic [SYN_W-1:0] syn1_reg;              // First stage, read only by syn2
   logic [SYN_W-1:0] syn2_reg;              // Second stage, safe to use
   logic             clk_syn1_reg;          // Calibration clock, first stage
   logic             clk_syn2_reg;          // Calibration clock, second stage
   logic             clk_prev_reg;          // Delayed for edge detection
   logic [SYN_W-1:0] ctl_hold_reg;          // Controls as they stood before the rise

   // First rise of a calibration already counts toward its length
   localparam logic [tcs_pkg::CAL_CNT_W-1:0] CAL_ONE = tcs_pkg::CAL_ZERO + 1'b1;

   // Two flops on every pin except bank_listen and measured_code before any logic reads it
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         syn1_reg     <= '0;
         syn2_reg     <= '0;
         clk_syn1_reg <= 1'b0;
         clk_syn2_reg <= 1'b0;
         clk_prev_reg <= 1'b0;
         ctl_hold_reg <= '0;
      end else begin
         syn1_reg     <= {cal_mode_select, cal_clear_n, block_enable, bank_parallel_load};
         syn2_reg     <= syn1_reg;
         clk_syn1_reg <= cal_clock;
         clk_syn2_reg <= clk_syn1_reg;
         clk_prev_reg <= clk_syn2_reg;
         // Lags the clock stage by one, so an edge sees pre-rise levels
         ctl_hold_reg <= syn2_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Decoded controls
   // ----------------------------------------------------------------------
   // sample on rise
   wire                               cal_edge = clk_syn2_reg && !clk_prev_reg;
   // Levels set on one rise are taken at the next rise
   wire                               mode_cal = ctl_hold_reg[SYN_W-1];
   wire                               clear_n  = ctl_hold_reg[SYN_W-2];
   wire [tcs_pkg::NUM_BLOCKS-1:0]     en_s     =
      ctl_hold_reg[tcs_pkg::NUM_BANKS +: tcs_pkg::NUM_BLOCKS];
   wire [tcs_pkg::NUM_BANKS-1:0]      load_s   = ctl_hold_reg[tcs_pkg::NUM_BANKS-1:0];
   wire                               one_hot  = $onehot(en_s);

   // ----------------------------------------------------------------------
   // Calibration blocks
   // ----------------------------------------------------------------------
   tcs_pkg::tcs_blk_e                 blk_st_reg   [tcs_pkg::NUM_BLOCKS];
   logic [tcs_pkg::CAL_CNT_W-1:0]     cal_cnt_reg  [tcs_pkg::NUM_BLOCKS];
   logic [tcs_pkg::CODE_BITS-1:0]     code_reg     [tcs_pkg::NUM_BLOCKS];

   genvar gb;
   generate
      for (gb = 0; gb < tcs_pkg::NUM_BLOCKS; gb++) begin : g_blk
         wire run = mode_cal && en_s[gb];
         wire clr = !clear_n && !en_s[gb];

         // Per-block calibration state and counter
         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               blk_st_reg[gb]  <= tcs_pkg::TCS_IDLE;
               cal_cnt_reg[gb] <= tcs_pkg::CAL_ZERO;
               code_reg[gb]    <= tcs_pkg::CODE_RESET;
            end else if (cal_edge) begin
               if (clr) begin
                  blk_st_reg[gb]  <= tcs_pkg::TCS_IDLE;
                  cal_cnt_reg[gb] <= tcs_pkg::CAL_ZERO;
               end else begin
                  unique case (blk_st_reg[gb])
                     tcs_pkg::TCS_IDLE: begin
                        // Start when enabled in calibration mode
                        if (run) begin
                           blk_st_reg[gb]  <= tcs_pkg::TCS_CAL;
                           cal_cnt_reg[gb] <= CAL_ONE;
                        end
                     end
                     tcs_pkg::TCS_CAL: begin
                        if (!run) begin
                           blk_st_reg[gb] <= tcs_pkg::TCS_IDLE;
                        end else if (cal_cnt_reg[gb] == tcs_pkg::CAL_LAST) begin
                           blk_st_reg[gb] <= tcs_pkg::TCS_DONE;
                           code_reg[gb]   <= {measured_code[tcs_pkg::CODE_BITS-1 -:
                                              tcs_pkg::PAR_BITS],
                                              measured_code[tcs_pkg::SERIES_BITS-1:0]};
                        end else begin
                           cal_cnt_reg[gb] <= cal_cnt_reg[gb] + 1'b1;
                        end
                     end
                     tcs_pkg::TCS_DONE: begin
                        // Hold code; recalibrate if run is still set once the counter has been parked
                        if (run && cal_cnt_reg[gb] == tcs_pkg::CAL_ZERO) begin
                           blk_st_reg[gb]  <= tcs_pkg::TCS_CAL;
                           cal_cnt_reg[gb] <= CAL_ONE;
                        end else begin
                           // Park the counter until a restart
                           cal_cnt_reg[gb] <= tcs_pkg::CAL_ZERO;
                        end
                     end
                     default: begin
                        blk_st_reg[gb] <= tcs_pkg::TCS_IDLE;
                     end
                  endcase
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Serializer
   // ----------------------------------------------------------------------
   logic [tcs_pkg::BIT_CNT_W-1:0]     bit_cnt_reg;     // Bits sent this pulse
   logic [$clog2(tcs_pkg::NUM_BLOCKS)-1:0] src_idx;    // Enabled block

   // Index of the single enabled block
   always_comb begin
      src_idx = '0;
      for (int i = 0; i < tcs_pkg::NUM_BLOCKS; i++) begin
         if (en_s[i]) begin
            src_idx = ($clog2(tcs_pkg::NUM_BLOCKS))'(i);
         end
      end
   end

   // enable means shift when select low
   wire shift_go  = cal_edge && !mode_cal && one_hot &&
                    (bit_cnt_reg <= tcs_pkg::BIT_LAST);
   wire [tcs_pkg::CODE_BITS-1:0] src_code = code_reg[src_idx];
   wire serial_bit = src_code[bit_cnt_reg[tcs_pkg::BIT_CNT_W-2:0]];

   // count 32 bits, restart per pulse
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         bit_cnt_reg <= tcs_pkg::BIT_ZERO;
      end else if (cal_edge) begin
         if (en_s == '0 || mode_cal) begin
            bit_cnt_reg <= tcs_pkg::BIT_ZERO;
         end else if (shift_go) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Serial path buffer
   // ----------------------------------------------------------------------
   logic fifo_in_ready;                     // Room for a bit
   logic fifo_out_valid;                    // Bit waiting for the banks
   logic fifo_out_bit;                      // Head bit

   tcs_fifo #(
      .WIDTH (tcs_pkg::FIFO_WIDTH),
      .DEPTH (tcs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .in_valid  (shift_go),
      .in_ready  (fifo_in_ready),
      .in_data   (serial_bit),
      .out_valid (fifo_out_valid),
      .out_ready (1'b1),
      .out_data  (fifo_out_bit)
   );

   // ----------------------------------------------------------------------
   // Banks
   // ----------------------------------------------------------------------
   logic [tcs_pkg::CODE_BITS-1:0]     bank_sh_reg [tcs_pkg::NUM_BANKS];
   logic [tcs_pkg::NUM_BANKS-1:0]     load_prev_reg;   // For rise detection
   logic [tcs_pkg::NUM_BANKS-1:0]     load_pend_reg;   // Load awaiting drain

   genvar gk;
   generate
      for (gk = 0; gk < tcs_pkg::NUM_BANKS; gk++) begin : g_bank
         wire load_rise = cal_edge && load_s[gk] && !load_prev_reg[gk];
         // Latch only once the buffered bits have all arrived
         wire do_load   = (load_pend_reg[gk] || load_rise) && !fifo_out_valid;

         // Shift in bits, LSB first, when listening
         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               bank_sh_reg[gk] <= tcs_pkg::CODE_RESET;
            end else if (fifo_out_valid && bank_listen[gk]) begin
               bank_sh_reg[gk] <= {fifo_out_bit, bank_sh_reg[gk][tcs_pkg::CODE_BITS-1:1]};
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!resetn) begin
               bank_code[gk*tcs_pkg::CODE_BITS +: tcs_pkg::CODE_BITS] <= tcs_pkg::CODE_RESET;
               load_pend_reg[gk] <= 1'b0;
               load_prev_reg[gk] <= 1'b0;
               bank_loading[gk]  <= 1'b0;
            end else begin
               if (cal_edge) begin
                  load_prev_reg[gk] <= load_s[gk];
               end
               load_pend_reg[gk] <= (load_pend_reg[gk] || load_rise) && !do_load;
               if (do_load) begin
                  bank_code[gk*tcs_pkg::CODE_BITS +: tcs_pkg::CODE_BITS] <= bank_sh_reg[gk];
               end
               bank_loading[gk] <= load_s[gk] || load_pend_reg[gk];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------------
   // Registered status per block and path readiness
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cal_busy          <= '0;
         cal_done          <= '0;
         serial_path_ready <= 1'b0;
      end else begin
         for (int i = 0; i < tcs_pkg::NUM_BLOCKS; i++) begin
            cal_busy[i] <= (blk_st_reg[i] == tcs_pkg::TCS_CAL);
            cal_done[i] <= (blk_st_reg[i] == tcs_pkg::TCS_DONE);
         end
         serial_path_ready <= fifo_in_ready;
      end
   end

endmodule : tcs_sequencer

/* tcs_seq_assertions.sv */
// Purpose: Port checks for the calibration sequencer
// Assumes: Design lags the pins by a few clk_sys cycles
// Notes:   Raw pin levels stand as causes
`timescale 1ns/1ns
module tcs_seq_assertions (
   input wire logic         clk_sys,
   input wire logic         resetn,
   input wire logic         cal_clock,
   input wire logic         cal_mode_select,
   input wire logic [7:0]   block_enable,
   input wire logic         cal_clear_n,
   input wire logic [7:0]   bank_parallel_load,
   input wire logic [7:0]   bank_listen,
   input wire logic [31:0]  measured_code,
   input wire logic [7:0]   cal_busy,
   input wire logic [7:0]   cal_done,
   input wire logic [7:0]   bank_loading,
   input wire logic [255:0] bank_code,
   input wire logic         serial_path_ready
);
   // ---------------------------------------------
   // Helper logic
   // ---------------------------------------------
   logic        cal_q;       // Calibration clock, one cycle late
   logic [7:0]  done_q;      // Done flags, one cycle late
   logic [3:0]  sel_low_cnt; // Cycles since select was high
   logic [10:0] busy_rises;  // Calibration rises while busy
   wire  [7:0]  new_done = cal_done & ~done_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Counters behind the checks
   always_ff @(posedge clk_sys) begin
      cal_q <= cal_clock;
      done_q <= resetn ? cal_done : 8'h00;
      if (!resetn || cal_mode_select) begin
         sel_low_cnt <= 4'h0;
      end else if (sel_low_cnt != 4'hf) begin
         sel_low_cnt <= sel_low_cnt + 4'h1;
      end
      if (cal_busy == 8'h00) begin
         busy_rises <= 11'h000;
      end else if (cal_clock && !cal_q && busy_rises != 11'h7ff) begin
         busy_rises <= busy_rises + 11'h001;
      end
   end
   sequence s_new_done;
      new_done != 8'h00;
   endsequence
   sequence s_clr_idle;
      $fell(cal_clear_n) && block_enable == 8'h00;
   endsequence
   // Clear pulse while some enabled block is calibrating
   sequence s_clr_busy;
      $fell(cal_clear_n) && (cal_busy & block_enable) != 8'h00;
   endsequence
   // An enabled block is still calibrating
   sequence s_blk_on;
      (cal_busy & block_enable) != 8'h00;
   endsequence
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   chk_busy_done_excl: assert property ((cal_busy & cal_done) == 8'h00)
      else $error("busy and done together");
   chk_busy_needs_sel: assert property ($rose(|cal_busy) |-> sel_low_cnt < 4'h8)
      else $error("busy without select");
   chk_done_from_busy: assert property (s_new_done |->
      (new_done & ($past(cal_busy) | $past(cal_busy, 2))) == new_done)
      else $error("done without calibration");
   chk_cal_length: assert property (s_new_done |-> busy_rises >= 11'h3e3)
      else $error("calibration too short");
   chk_load_shows: assert property (|bank_parallel_load |->
      ##[0:6] ((bank_loading & bank_parallel_load) != 8'h00))
      else $error("load not flagged");
   chk_code_on_load: assert property (!$stable(bank_code) |->
      (bank_loading | $past(bank_loading)) != 8'h00)
      else $error("code moved without load");
   chk_clear_idles: assert property (s_clr_idle |-> ##[1:24] cal_done == 8'h00)
      else $error("clear ignored");
   chk_busy_kept: assert property (s_clr_busy |=> s_blk_on [*8] ##1 s_blk_on [*8])
      else $error("calibration disturbed");
endmodule : tcs_seq_assertions
bind tcs_sequencer tcs_seq_assertions u_chk (.clk_sys(clk_sys), .resetn(resetn),
   .cal_clock(cal_clock), .cal_mode_select(cal_mode_select), .block_enable(block_enable),
   .cal_clear_n(cal_clear_n), .bank_parallel_load(bank_parallel_load),
   .bank_listen(bank_listen), .measured_code(measured_code), .cal_busy(cal_busy),
   .cal_done(cal_done), .bank_loading(bank_loading), .bank_code(bank_code),
   .serial_path_ready(serial_path_ready));

/* tcs_user_model.sv */
// Purpose: Fabric user logic driving the calibration pins
// Assumes: Calibration clock free-running, 8 clk_sys per period
// Notes:   Pins change just after a calibration clock rise
`timescale 1ns/1ns
module tcs_user_model (
   input  wire logic       clk_sys,
   output logic            cal_clock,
   output logic            cal_mode_select,
   output logic [7:0]      block_enable,
   output logic            cal_clear_n,
   output logic [7:0]      bank_parallel_load
);
   logic [1:0] half_cnt; // Half period counter
   initial begin
      half_cnt = 2'h0;
      cal_clock = 1'b0;
      cal_mode_select = 1'b0;
      block_enable = 8'h00;
      cal_clear_n = 1'b1;
      bank_parallel_load = 8'h00;
   end
   always @(negedge clk_sys) begin
      half_cnt <= half_cnt + 2'h1;
      if (half_cnt == 2'h3) begin
         cal_clock <= ~cal_clock;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge cal_clock);
   endtask : tick
   task automatic cal_start(input logic [7:0] mask);
      tick(1);
      cal_clear_n = 1'b0;
      tick(1);
      cal_clear_n = 1'b1;
      cal_mode_select = 1'b1;
      tick(1);
      block_enable = block_enable | mask;
   endtask : cal_start
   // End the hold of the masked blocks
   task automatic cal_stop(input logic [7:0] mask);
      tick(1);
      block_enable = block_enable & ~mask;
   endtask : cal_stop
   task automatic end_cal();
      tick(1);
      cal_mode_select = 1'b0;
   endtask : end_cal
   task automatic shift(input int k, input logic [7:0] mask);
      tick(2);
      block_enable[k] = 1'b1;
      tick(32);
      block_enable[k] = 1'b0;
      tick(1);
      bank_parallel_load = mask;
      tick(1);
      bank_parallel_load = 8'h00;
      tick(1);
   endtask : shift
endmodule : tcs_user_model

/* tb.sv */
// Purpose: Self-checking bench for the calibration sequencer
// Assumes: User model drives all calibration pins except bank_listen and measured_code
// Notes:   Codes are checked after the bank loads
`timescale 1ns/1ns
module tb;
   localparam logic [31:0] CODE_A = 32'ha5c3_5a3c; // First code
   localparam logic [31:0] CODE_B = 32'h5a3c_a5c3; // Second code, every bit flipped
   logic clk_sys, resetn, cal_clock, sel, clr_n, path_rdy;
   logic [7:0] en, load, listen, busy, done, loading;
   logic [31:0] code;
   logic [255:0] bank_code;
   int error_cnt, tests_run, cyc;
   tcs_sequencer dut (.clk_sys(clk_sys), .resetn(resetn), .cal_clock(cal_clock),
      .cal_mode_select(sel), .block_enable(en), .cal_clear_n(clr_n),
      .bank_parallel_load(load), .bank_listen(listen), .measured_code(code),
      .cal_busy(busy), .cal_done(done), .bank_loading(loading), .bank_code(bank_code),
      .serial_path_ready(path_rdy));
   tcs_user_model u_user (.clk_sys(clk_sys), .cal_clock(cal_clock), .cal_mode_select(sel),
      .block_enable(en), .cal_clear_n(clr_n), .bank_parallel_load(load));
   // Clock generator
   always #20 clk_sys = ~clk_sys;
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Let a calibration rise land
   task automatic settle();
      u_user.tick(1);
      repeat (4) @(negedge clk_sys);
   endtask : settle
   task automatic wrap_up();
      $display("Counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic t_single();
      code = CODE_A;
      u_user.cal_start(8'h04);
      u_user.tick(500);
      check(32'(busy), 32'h04);
      check(32'(done), 32'h00);
      u_user.tick(499);
      check(32'(done), 32'h00);
      u_user.cal_stop(8'h04);
      settle();
      u_user.end_cal();
      check(32'(done), 32'h04);
      $display("single calibration done");
   endtask : t_single
   task automatic t_shift_a();
      listen = 8'h7f;
      u_user.shift(2, 8'h05);
      repeat (16) @(negedge clk_sys);
      check(bank_code[31:0], CODE_A);
      check(bank_code[95:64], CODE_A);
      check(bank_code[63:32], 32'h0);
      check(32'(loading), 32'h00);
      check(32'(path_rdy), 32'h1);
      $display("first shift done");
   endtask : t_shift_a
   task automatic t_overlap();
      code = CODE_B;
      u_user.cal_start(8'h20);
      u_user.tick(100);
      u_user.cal_start(8'h40);
      u_user.tick(896);
      u_user.cal_stop(8'h20);
      settle();
      check(32'(done), 32'h20);
      check(32'(busy), 32'h40);
      u_user.tick(101);
      u_user.cal_stop(8'h40);
      settle();
      u_user.end_cal();
      check(32'(done), 32'h60);
      $display("overlap done");
   endtask : t_overlap
   task automatic t_shift_b();
      listen = 8'hfa;
      u_user.shift(6, 8'hfa);
      repeat (16) @(negedge clk_sys);
      check(bank_code[255:224], CODE_B);
      check(bank_code[63:32], CODE_B);
      check(bank_code[31:0], CODE_A);
      check(bank_code[95:64], CODE_A);
      $display("second shift done");
   endtask : t_shift_b
   task automatic t_abort();
      u_user.cal_start(8'h9b);
      u_user.tick(10);
      settle();
      check(32'(busy), 32'h9b);
      check(32'(done), 32'h00);
      u_user.cal_stop(8'h9b);
      settle();
      check(32'(busy), 32'h00);
      check(32'(done), 32'h00);
      u_user.end_cal();
      $display("abort done");
   endtask : t_abort
   // Main sequence
   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      listen = 8'h00;
      code = 32'h0;
      error_cnt = 0;
      tests_run = 0;
      cyc = 0;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (8) @(negedge clk_sys);
      t_single();
      t_shift_a();
      t_overlap();
      t_shift_b();
      t_abort();
      wrap_up();
   end
endmodule : tb
